/* design/ssm_pkg.sv */
// Constants, register map and bandwidth table of the spread spectrum modem core.
// Assumes a single 50 MHz system clock and byte-wide serial register access.
package ssm_pkg;

    // ========================================================================
    // Register addresses (7-bit serial address space)
    localparam logic [6:0] SSM_ADDR_FIFO = 7'h00;
    localparam logic [6:0] SSM_ADDR_OP_MODE = 7'h01;
    localparam logic [6:0] SSM_ADDR_STATUS = 7'h18;
    localparam logic [6:0] SSM_ADDR_CFG_ONE = 7'h1D;
    localparam logic [6:0] SSM_ADDR_CFG_TWO = 7'h1E;
    localparam logic [6:0] SSM_ADDR_PAY_LEN = 7'h22;
    localparam logic [6:0] SSM_ADDR_DET_OPT = 7'h31;
    localparam logic [6:0] SSM_ADDR_DET_THR = 7'h37;

    // ========================================================================
    // Field positions
    localparam int SSM_OPM_SPREAD_BIT = 7;
    localparam int SSM_OPM_MODE_LSB = 0;
    localparam int SSM_CFG1_BW_LSB = 4;
    localparam int SSM_CFG1_CR_LSB = 1;
    localparam int SSM_CFG1_HDRLESS_BIT = 0;
    localparam int SSM_CFG2_SF_LSB = 4;
    localparam int SSM_CFG2_SLOW_BIT = 3;
    localparam int SSM_CFG2_CRC_BIT = 2;

    // ========================================================================
    // Reset values
    localparam logic [7:0] SSM_OPM_RST = 8'h00;
    localparam logic [7:0] SSM_CFG1_RST = 8'h72;
    localparam logic [7:0] SSM_CFG2_RST = 8'h70;
    localparam logic [7:0] SSM_PAY_LEN_RST = 8'h01;
    localparam logic [7:0] SSM_DET_OPT_RST = 8'h03;
    localparam logic [7:0] SSM_DET_THR_RST = 8'h0A;

    // ========================================================================
    // Operating modes held in the op mode register
    localparam logic [2:0] SSM_MODE_SLEEP = 3'h0;
    localparam logic [2:0] SSM_MODE_STBY = 3'h1;
    localparam logic [2:0] SSM_MODE_TX = 3'h3;
    localparam logic [2:0] SSM_MODE_RX = 3'h5;

    // ========================================================================
    // Spreading factor, coding rate and bandwidth limits
    localparam logic [3:0] SSM_SF_MIN = 4'h6;
    localparam logic [3:0] SSM_SF_MAX = 4'hC;
    localparam logic [2:0] SSM_SF6_OPT_PATTERN = 3'h5;
    localparam logic [7:0] SSM_SF6_THR_VALUE = 8'h0C;
    localparam logic [2:0] SSM_CR_HEADER = 3'h4;
    localparam logic [3:0] SSM_BW_CODE_MAX = 4'h9;

    // ========================================================================
    // Timing
    localparam int SSM_CLK_HZ = 50_000_000;
    localparam int SSM_CLK_PERIOD_NS = 20;
    localparam logic [15:0] SSM_PREAMBLE_SYMS = 16'h000C;
    localparam logic [23:0] SSM_SLOW_SYM_MS = 24'h000010;
    localparam logic [23:0] SSM_MS_PER_S = 24'h0003E8;

    // Double sideband bandwidth in Hz for each bandwidth code
    function automatic logic [18:0] ssm_bw_hz(input logic [3:0] code);
        logic [18:0] hz;
        unique case (code)
            4'h0: hz = 19'h01E78;
            4'h1: hz = 19'h028A0;
            4'h2: hz = 19'h03CF0;
            4'h3: hz = 19'h05140;
            4'h4: hz = 19'h079E0;
            4'h5: hz = 19'h0A2E4;
            4'h6: hz = 19'h0F424;
            4'h7: hz = 19'h1E848;
            4'h8: hz = 19'h3D090;
            4'h9: hz = 19'h7A120;
            default: hz = 19'h00000;
        endcase
        return hz;
    endfunction : ssm_bw_hz

endpackage : ssm_pkg

/* design/ssm_symbol_timer.sv */
// Chip and symbol tick generator of the spread spectrum modem.
// Assumes sf and bw_hz stay stable while run is high.
`timescale 1ns/1ps
`default_nettype none
module ssm_symbol_timer
    import ssm_pkg::*;
#(
    parameter int CLK_HZ = SSM_CLK_HZ
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Settings
    input wire logic run,
    input wire logic [3:0] sf,
    input wire logic [18:0] bw_hz,
    // Ticks
    output logic chip_tick,
    output logic sym_tick
);
    localparam logic [26:0] CLK_HZ_W = 27'(CLK_HZ);

    logic [26:0] acc_q;
    logic [11:0] chip_cnt_q;
    logic [26:0] acc_sum;
    logic chip_wrap;
    logic [11:0] chip_last;
    logic sym_end;

    assign acc_sum = acc_q + {8'h00, bw_hz};
    assign chip_wrap = acc_sum >= CLK_HZ_W;
    // symbol is two to sf chips
    assign chip_last = 12'((13'h0001 << sf) - 13'h0001);
    assign sym_end = chip_wrap && (chip_cnt_q == chip_last);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_q <= 27'h0000000;
            chip_cnt_q <= 12'h000;
            chip_tick <= 1'b0;
            sym_tick <= 1'b0;
        end
        else if (!run)
        begin
            acc_q <= 27'h0000000;
            chip_cnt_q <= 12'h000;
            chip_tick <= 1'b0;
            sym_tick <= 1'b0;
        end
        else
        begin
            acc_q <= chip_wrap ? acc_sum - CLK_HZ_W : acc_sum;
            chip_tick <= chip_wrap;
            sym_tick <= sym_end;
            if (chip_wrap)
                chip_cnt_q <= sym_end ? 12'h000 : chip_cnt_q + 12'h001;
        end
    end

    sym_len_a: assert property (@(posedge clk) disable iff (!nrst)
        sym_tick |-> $past(chip_cnt_q) == $past(chip_last))
        else $error("symbol ended at wrong chip count");

    chip_run_a: assert property (@(posedge clk) disable iff (!nrst)
        chip_tick |-> $past(run))
        else $error("chip tick without run");

endmodule : ssm_symbol_timer
`default_nettype wire

/* design/ssm_modem.sv */
// Spread spectrum modem core: serial register file, data buffer, packet framer.
// Assumes SPI mode 0 pins from outside and same-clock receive demodulator inputs.
`timescale 1ns/1ps
`default_nettype none
module ssm_modem
    import ssm_pkg::*;
#(
    parameter int FIFO_DEPTH = 256,
    parameter int CLK_HZ = SSM_CLK_HZ
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Serial register port
    input wire logic SCK,
    input wire logic NSS_N,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE,
    // Transmit stream to modulator
    output logic TX_BYTE_VALID,
    output logic [7:0] TX_BYTE,
    output logic [2:0] TX_RATE,
    output logic [1:0] TX_FIELD,
    output logic TX_LOWRATE,
    output logic CHIP_TICK,
    output logic SYMBOL_TICK,
    // Receive side from demodulator
    input wire logic RX_HDR_VALID,
    input wire logic RX_HDR_CHECK_OK,
    input wire logic [2:0] RX_HDR_RATE,
    input wire logic RX_BYTE_VALID,
    input wire logic [7:0] RX_BYTE,
    output logic [2:0] RX_RATE,
    // Demodulator tuning and mode
    output logic [2:0] DETECT_OPT,
    output logic [7:0] DETECT_THRESH,
    output logic SPREAD_MODE
);
    localparam int PW = $clog2(FIFO_DEPTH);

    typedef enum logic [2:0] {FR_IDLE, FR_PREAMBLE, FR_HEADER, FR_PAYLOAD, FR_CHECK} ssm_fr_t;

    // ========================================================================
    // Pin synchronisers and serial edges
    logic [1:0] sck_s_q, nss_s_q, mosi_s_q;
    logic sck_prev_q;
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            sck_s_q <= 2'h0;
            nss_s_q <= 2'h3;
            mosi_s_q <= 2'h0;
            sck_prev_q <= 1'b0;
        end
        else
        begin
            sck_s_q <= {sck_s_q[0], SCK};
            nss_s_q <= {nss_s_q[0], NSS_N};
            mosi_s_q <= {mosi_s_q[0], MOSI};
            sck_prev_q <= sck_s_q[1];
        end
    end
    wire active = ~nss_s_q[1];
    wire sck_rise = active & sck_s_q[1] & ~sck_prev_q;
    wire sck_fall = active & ~sck_s_q[1] & sck_prev_q;

    // ========================================================================
    // Serial byte engine
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_in_q, shift_out_q;
    logic first_q, wr_q;
    logic [6:0] addr_q;
    wire byte_done = sck_rise & (bit_cnt_q == 3'h7);
    wire [7:0] rx_byte = {shift_in_q[6:0], mosi_s_q[1]};
    wire [6:0] addr_inc = (addr_q == SSM_ADDR_FIFO) ? addr_q : addr_q + 7'h01;
    wire [6:0] rd_addr = first_q ? rx_byte[6:0] : addr_inc;
    wire rd_load = byte_done & (first_q ? ~rx_byte[7] : ~wr_q);
    wire wr_stb = byte_done & ~first_q & wr_q;

    // ========================================================================
    // Register file
    logic [7:0] op_mode_q, cfg_one_q, cfg_two_q, pay_len_q, det_opt_q, det_thr_q;
    logic spread_q;
    assign spread_q = op_mode_q[SSM_OPM_SPREAD_BIT];
    wire [2:0] mode = op_mode_q[SSM_OPM_MODE_LSB +: 3];
    wire [3:0] bw_code = cfg_one_q[SSM_CFG1_BW_LSB +: 4];
    wire [2:0] code_rate = cfg_one_q[SSM_CFG1_CR_LSB +: 3];
    wire [3:0] sf = cfg_two_q[SSM_CFG2_SF_LSB +: 4];
    wire crc_on = cfg_two_q[SSM_CFG2_CRC_BIT];
    // spread map visible only in spread mode
    wire wr_opm = wr_stb & (addr_q == SSM_ADDR_OP_MODE);
    wire wr_map = wr_stb & spread_q;
    wire wr_fifo = wr_map & (addr_q == SSM_ADDR_FIFO);
    wire rd_fifo = rd_load & spread_q & (rd_addr == SSM_ADDR_FIFO);
    wire sf_ok = (sf >= SSM_SF_MIN) && (sf <= SSM_SF_MAX);
    wire bw_ok = bw_code <= SSM_BW_CODE_MAX;
    wire sf6 = sf == SSM_SF_MIN;
    wire headerless = cfg_one_q[SSM_CFG1_HDRLESS_BIT] | sf6;
    wire sf6_bad = sf6 & ((det_opt_q[2:0] != SSM_SF6_OPT_PATTERN)
        | (det_thr_q != SSM_SF6_THR_VALUE));
    // symbol longer than limit needs slow rate bit
    wire [23:0] sym_scaled = 24'((24'h000001 << sf) * SSM_MS_PER_S);
    wire [23:0] bw_scaled = 24'({5'h00, ssm_bw_hz(bw_code)} * SSM_SLOW_SYM_MS);
    wire slow_needed = sym_scaled > bw_scaled;
    wire [18:0] bw_hz = ssm_bw_hz(bw_code);

    // ========================================================================
    // Packet framer state
    ssm_fr_t state_q;
    logic [15:0] cnt_q;
    logic [15:0] sum_q;
    logic [PW-1:0] host_ptr_q, modem_ptr_q;
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic sym_tick, chip_tick;
    wire busy = state_q != FR_IDLE;
    wire start = ~busy & spread_q & (mode == SSM_MODE_TX) & sf_ok & bw_ok;
    wire rx_wr = spread_q & (mode == SSM_MODE_RX) & RX_BYTE_VALID;
    wire [7:0] fifo_out = fifo_mem[modem_ptr_q];
    wire [7:0] hdr_flags = {4'h0, code_rate, crc_on};
    wire [7:0] hdr_check = pay_len_q ^ hdr_flags;
    wire last_pre = cnt_q == SSM_PREAMBLE_SYMS - 16'h0001;
    wire last_pay = cnt_q[7:0] == pay_len_q - 8'h01;
    wire tx_done = sym_tick & (((state_q == FR_PAYLOAD) & last_pay & ~crc_on)
        | ((state_q == FR_CHECK) & (cnt_q[0])));
    wire [7:0] status = {4'h0, sf6_bad, slow_needed, ~sf_ok, busy};
    wire [7:0] rd_data =
        (rd_addr == SSM_ADDR_OP_MODE) ? op_mode_q :
        !spread_q ? 8'h00 :
        (rd_addr == SSM_ADDR_FIFO) ? fifo_mem[host_ptr_q] :
        (rd_addr == SSM_ADDR_STATUS) ? status :
        (rd_addr == SSM_ADDR_CFG_ONE) ? cfg_one_q :
        (rd_addr == SSM_ADDR_CFG_TWO) ? cfg_two_q :
        (rd_addr == SSM_ADDR_PAY_LEN) ? pay_len_q :
        (rd_addr == SSM_ADDR_DET_OPT) ? det_opt_q :
        (rd_addr == SSM_ADDR_DET_THR) ? det_thr_q : 8'h00;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            bit_cnt_q <= 3'h0;
            shift_in_q <= 8'h00;
            shift_out_q <= 8'h00;
            first_q <= 1'b1;
            wr_q <= 1'b0;
            addr_q <= 7'h00;
            MISO <= 1'b0;
            MISO_OE <= 1'b0;
        end
        else
        begin
            MISO_OE <= active;
            if (!active)
            begin
                bit_cnt_q <= 3'h0;
                first_q <= 1'b1;
            end
            else if (sck_rise)
            begin
                shift_in_q <= rx_byte;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (byte_done)
            begin
                first_q <= 1'b0;
                addr_q <= rd_addr;
                if (first_q)
                    wr_q <= rx_byte[7];
            end
            if (rd_load)
                shift_out_q <= rd_data;
            else if (byte_done)
                shift_out_q <= 8'h00;
            else if (sck_fall)
            begin
                MISO <= shift_out_q[7];
                shift_out_q <= {shift_out_q[6:0], 1'b0};
            end
        end
    end

    // Register writes; mode returns to standby at packet end or refused start
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            op_mode_q <= SSM_OPM_RST;
            cfg_one_q <= SSM_CFG1_RST;
            cfg_two_q <= SSM_CFG2_RST;
            pay_len_q <= SSM_PAY_LEN_RST;
            det_opt_q <= SSM_DET_OPT_RST;
            det_thr_q <= SSM_DET_THR_RST;
        end
        else
        begin
            // map switch only taken in sleep
            if (wr_opm)
                op_mode_q <= {(mode == SSM_MODE_SLEEP) ? rx_byte[7] : spread_q, rx_byte[6:0]};
            else if (tx_done | (~busy & (mode == SSM_MODE_TX) & ~(spread_q & sf_ok & bw_ok)))
                op_mode_q[SSM_OPM_MODE_LSB +: 3] <= SSM_MODE_STBY;
            if (wr_map & (addr_q == SSM_ADDR_CFG_ONE))
                cfg_one_q <= rx_byte;
            if (wr_map & (addr_q == SSM_ADDR_CFG_TWO))
                cfg_two_q <= rx_byte;
            if (wr_map & (addr_q == SSM_ADDR_PAY_LEN))
                pay_len_q <= rx_byte;
            if (wr_map & (addr_q == SSM_ADDR_DET_OPT))
                det_opt_q <= rx_byte;
            if (wr_map & (addr_q == SSM_ADDR_DET_THR))
                det_thr_q <= rx_byte;
        end
    end

    // dual port buffer: host port and modem port
    always_ff @(posedge CLK)
    begin
        if (wr_fifo)
            fifo_mem[host_ptr_q] <= rx_byte;
        if (rx_wr)
            fifo_mem[modem_ptr_q] <= RX_BYTE;
    end

    // ========================================================================
    // Framer: preamble, optional header, payload, optional check
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_q <= FR_IDLE;
            cnt_q <= 16'h0000;
            sum_q <= 16'h0000;
            host_ptr_q <= '0;
            modem_ptr_q <= '0;
            TX_BYTE_VALID <= 1'b0;
            TX_BYTE <= 8'h00;
            TX_RATE <= 3'h0;
            TX_FIELD <= 2'h0;
        end
        else
        begin
            TX_BYTE_VALID <= 1'b0;
            if (wr_opm)
                host_ptr_q <= '0;
            else if (wr_fifo | rd_fifo)
                host_ptr_q <= host_ptr_q + PW'(1);
            if (rx_wr)
                modem_ptr_q <= modem_ptr_q + PW'(1);
            if (wr_opm & (rx_byte[2:0] == SSM_MODE_RX))
                modem_ptr_q <= '0;
            unique case (state_q)
                FR_IDLE:
                    if (start)
                    begin
                        state_q <= FR_PREAMBLE;
                        cnt_q <= 16'h0000;
                        sum_q <= 16'h0000;
                        modem_ptr_q <= '0;
                    end
                FR_PREAMBLE:
                    if (sym_tick)
                    begin
                        TX_BYTE_VALID <= 1'b1;
                        TX_BYTE <= 8'h00;
                        TX_FIELD <= 2'h0;
                        TX_RATE <= code_rate;
                        cnt_q <= last_pre ? 16'h0000 : cnt_q + 16'h0001;
                        if (last_pre)
                            state_q <= headerless ? FR_PAYLOAD : FR_HEADER;
                    end
                // header: length, rate, crc flag, check at 4/8
                FR_HEADER:
                    if (sym_tick)
                    begin
                        TX_BYTE_VALID <= 1'b1;
                        TX_FIELD <= 2'h1;
                        TX_RATE <= SSM_CR_HEADER;
                        TX_BYTE <= (cnt_q[1:0] == 2'h0) ? pay_len_q :
                            (cnt_q[1:0] == 2'h1) ? hdr_flags : hdr_check;
                        cnt_q <= (cnt_q[1:0] == 2'h2) ? 16'h0000 : cnt_q + 16'h0001;
                        if (cnt_q[1:0] == 2'h2)
                            state_q <= FR_PAYLOAD;
                    end
                FR_PAYLOAD:
                    if (sym_tick)
                    begin
                        TX_BYTE_VALID <= 1'b1;
                        TX_FIELD <= 2'h2;
                        TX_RATE <= code_rate;
                        TX_BYTE <= fifo_out;
                        sum_q <= sum_q + {8'h00, fifo_out};
                        modem_ptr_q <= modem_ptr_q + PW'(1);
                        cnt_q <= last_pay ? 16'h0000 : cnt_q + 16'h0001;
                        if (last_pay)
                            state_q <= crc_on ? FR_CHECK : FR_IDLE;
                    end
                FR_CHECK:
                    if (sym_tick)
                    begin
                        TX_BYTE_VALID <= 1'b1;
                        TX_FIELD <= 2'h3;
                        TX_RATE <= code_rate;
                        TX_BYTE <= cnt_q[0] ? sum_q[7:0] : sum_q[15:8];
                        cnt_q <= cnt_q + 16'h0001;
                        if (cnt_q[0])
                            state_q <= FR_IDLE;
                    end
            endcase
        end
    end

    // ========================================================================
    // Registered side outputs
    logic [2:0] hdr_rate_q;
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            hdr_rate_q <= 3'h0;
            RX_RATE <= 3'h0;
            TX_LOWRATE <= 1'b0;
            DETECT_OPT <= 3'h0;
            DETECT_THRESH <= 8'h00;
            SPREAD_MODE <= 1'b0;
        end
        else
        begin
            // rate from a checked header only
            if (RX_HDR_VALID & RX_HDR_CHECK_OK)
                hdr_rate_q <= RX_HDR_RATE;
            RX_RATE <= headerless ? code_rate : hdr_rate_q;
            TX_LOWRATE <= cfg_two_q[SSM_CFG2_SLOW_BIT];
            DETECT_OPT <= det_opt_q[2:0];
            DETECT_THRESH <= det_thr_q;
            SPREAD_MODE <= spread_q;
        end
    end

    ssm_symbol_timer #(.CLK_HZ(CLK_HZ)) u_timer (
        .clk(CLK),
        .nrst(NRST),
        .run(busy),
        .sf(sf),
        .bw_hz(bw_hz),
        .chip_tick(chip_tick),
        .sym_tick(sym_tick)
    );
    assign CHIP_TICK = chip_tick;
    assign SYMBOL_TICK = sym_tick;

    // ========================================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    hdr_rate_a: assert property (
        TX_BYTE_VALID && TX_FIELD == 2'h1 |-> TX_RATE == SSM_CR_HEADER)
        else $error("header not sent at strongest rate");
    sf6_nohdr_a: assert property (
        state_q == FR_PREAMBLE && sym_tick && last_pre && sf6 |=> state_q == FR_PAYLOAD)
        else $error("header sent at factor 6");
    sf_range_a: assert property (
        $rose(busy) |-> $past(sf) >= SSM_SF_MIN && $past(sf) <= SSM_SF_MAX)
        else $error("started with unsupported factor");
    pkt_order_a: assert property (
        state_q == FR_PAYLOAD && $past(state_q) != FR_PAYLOAD |->
        $past(state_q) inside {FR_PREAMBLE, FR_HEADER})
        else $error("payload not after preamble or header");
    map_hide_a: assert property (
        rd_load && !spread_q && rd_addr != SSM_ADDR_OP_MODE |=> shift_out_q == 8'h00)
        else $error("spread register visible in conventional map");
    map_keep_a: assert property (
        wr_opm && mode != SSM_MODE_SLEEP |=> spread_q == $past(spread_q))
        else $error("map changed outside sleep");
    pay_rate_a: assert property (
        TX_BYTE_VALID && TX_FIELD == 2'h2 |-> TX_RATE == $past(code_rate))
        else $error("payload rate differs from setting");
    rx_rate_a: assert property (
        RX_HDR_VALID && RX_HDR_CHECK_OK && !headerless ##1 !headerless |=>
        RX_RATE == $past(RX_HDR_RATE, 2))
        else $error("header rate not applied");
    done_stby_a: assert property (
        tx_done |=> !busy && mode == SSM_MODE_STBY)
        else $error("mode not back to standby after packet");
    fifo_rd_a: assert property (
        rd_fifo && !wr_opm |=> host_ptr_q == $past(host_ptr_q) + 1'b1)
        else $error("buffer pointer did not advance");

    explicit_c: cover property (state_q == FR_HEADER ##1 state_q == FR_PAYLOAD);
    check_c: cover property (tx_done && state_q == FR_CHECK);
    rx_hdr_c: cover property (RX_HDR_VALID && RX_HDR_CHECK_OK);
    map_c: cover property (wr_opm && mode == SSM_MODE_SLEEP && rx_byte[7]);

endmodule : ssm_modem
`default_nettype wire

/* verif/ssm_peer_radio.sv */
// Peer radio stand-in: counts transmit slots, sends one decoded header.
// Assumes it shares the modem core clock.
`timescale 1ns/1ps
`default_nettype none
module ssm_peer_radio (
    // Clock and control
    input wire logic clk,
    input wire logic send_hdr,
    // Modem transmit side
    input wire logic tx_valid,
    // Demodulator side
    output logic hdr_valid,
    output logic [2:0] hdr_rate,
    output int slots
);
    assign hdr_rate = 3'h3;
    initial slots = 0;
    always @(negedge clk) hdr_valid <= send_hdr;
    always @(posedge clk) if (tx_valid) slots <= slots + 1;
endmodule : ssm_peer_radio
`default_nettype wire

/* verif/spread_spectrum_modem_params_test.sv */
// Self-checking bench of the modem core with a peer radio model.
// Assumes ssm_pkg and ssm_modem are compiled first.
`timescale 1ns/1ps
`default_nettype none
module spread_spectrum_modem_params_test;
    // ==================== Signals
    logic CLK = 0, NRST = 0, SCK = 0, NSS_N = 1, MOSI = 0, send_hdr = 0;
    logic MISO, hv, SPREAD_MODE;
    logic [2:0] hr, RX_RATE, DETECT_OPT, TX_RATE;
    logic [1:0] TX_FIELD;
    logic [7:0] TX_BYTE, DETECT_THRESH, r, RX_BYTE = 8'h00;
    logic TX_BYTE_VALID, SYMBOL_TICK, TX_LOWRATE, CHIP_TICK, MISO_OE, RX_BYTE_VALID = 1'b0;
    int slots, failures = 0, checks_done = 0, t;
    always #10 CLK = ~CLK;
    ssm_modem #(.CLK_HZ(1_000_000)) ssm_modem_inst (.CLK(CLK), .NRST(NRST), .SCK(SCK),
        .NSS_N(NSS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE),
        .TX_BYTE_VALID(TX_BYTE_VALID), .TX_BYTE(TX_BYTE), .TX_RATE(TX_RATE),
        .TX_FIELD(TX_FIELD), .TX_LOWRATE(TX_LOWRATE), .CHIP_TICK(CHIP_TICK),
        .SYMBOL_TICK(SYMBOL_TICK), .RX_HDR_VALID(hv), .RX_HDR_CHECK_OK(hv),
        .RX_HDR_RATE(hr), .RX_BYTE_VALID(RX_BYTE_VALID), .RX_BYTE(RX_BYTE), .RX_RATE(RX_RATE),
        .DETECT_OPT(DETECT_OPT), .DETECT_THRESH(DETECT_THRESH), .SPREAD_MODE(SPREAD_MODE));
    ssm_peer_radio ssm_peer_radio_inst (.clk(CLK), .send_hdr(send_hdr),
        .tx_valid(TX_BYTE_VALID), .hdr_valid(hv), .hdr_rate(hr), .slots(slots));
    task automatic results();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Serial frame, mode 0, address byte then one data byte
    task automatic spi(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] s;
        s = {a, d};
        NSS_N = 1'b0;
        repeat (6) @(negedge CLK);
        for (int i = 15; i >= 0; i--)
        begin
            MOSI = s[i];
            repeat (6) @(negedge CLK);
            SCK = 1'b1;
            if (i < 8) r[i] = MISO;
            if (i == 0) chk({7'h00, MISO_OE}, 8'h01);
            repeat (6) @(negedge CLK);
            SCK = 1'b0;
        end
        repeat (6) @(negedge CLK);
        NSS_N = 1'b1;
        repeat (6) @(negedge CLK);
        chk({7'h00, MISO_OE}, 8'h00);
    endtask : spi
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        spi(a, 8'h00);
        chk(r, exp);
    endtask : rd
    task automatic test_map();
        rd(8'h1D, 8'h00);
        spi(8'h81, 8'h80);
        chk({7'h00, SPREAD_MODE}, 8'h01);
        rd(8'h1D, 8'h72);
        rd(8'h1E, 8'h70);
    endtask : test_map
    task automatic test_rates();
        send_hdr <= 1'b1;
        @(negedge CLK);
        send_hdr <= 1'b0;
        repeat (4) @(negedge CLK);
        chk({5'h00, RX_RATE}, 8'h03);
        spi(8'h9D, 8'h73);
        repeat (4) @(negedge CLK);
        chk({5'h00, RX_RATE}, 8'h01);
    endtask : test_rates
    task automatic test_sf6_tune();
        spi(8'hB1, 8'h05);
        spi(8'hB7, 8'h0C);
        chk({5'h00, DETECT_OPT}, 8'h05);
        chk(DETECT_THRESH, 8'h0C);
    endtask : test_sf6_tune
    task automatic test_tx_frame();
        spi(8'h9D, 8'h93);
        spi(8'h9E, 8'h60);
        spi(8'h80, 8'h5A);
        spi(8'h81, 8'h83);
        while (!SYMBOL_TICK) @(negedge CLK);
        t = 0;
        do
        begin
            t++;
            @(negedge CLK);
        end while (!SYMBOL_TICK);
        chk(t[7:0], 8'h80);
        while (slots < 13) @(negedge CLK);
        repeat (300) @(negedge CLK);
        chk(slots[7:0], 8'h0D);
        chk(TX_BYTE, 8'h5A);
        rd(8'h01, 8'h81);
    endtask : test_tx_frame
    task automatic test_explicit();
        logic [7:0] b;
        spi(8'h9D, 8'h92);
        spi(8'h9E, 8'h7C);
        spi(8'h80, 8'hA5);
        spi(8'h81, 8'h83);
        chk({7'h00, TX_LOWRATE}, 8'h01);
        while (!CHIP_TICK) @(negedge CLK);
        t = 0;
        do
        begin
            t++;
            @(negedge CLK);
        end while (!CHIP_TICK);
        chk(t[7:0], 8'h02);
        for (int i = 0; i < 18; i++)
        begin
            while (!TX_BYTE_VALID) @(negedge CLK);
            b = (i < 12) ? 8'h00 : (i < 15) ? 8'h01 : (i == 15) ? 8'h02 : 8'h03;
            chk({6'h00, TX_FIELD}, b);
            b = (i inside {[12:14]}) ? 8'h04 : 8'h01;
            chk({5'h00, TX_RATE}, b);
            // Header: length, rate and check flag, length xor flags
            b = (i == 12) ? 8'h01 : (i == 13) ? 8'h03 : (i == 14) ? 8'h02 : 8'h00;
            chk(TX_BYTE, (i == 15 || i == 17) ? 8'hA5 : b);
            @(negedge CLK);
        end
        rd(8'h01, 8'h81);
    endtask : test_explicit
    task automatic test_rx();
        spi(8'h81, 8'h85);
        RX_BYTE = 8'h3C;
        RX_BYTE_VALID = 1'b1;
        @(negedge CLK);
        RX_BYTE_VALID = 1'b0;
        rd(8'h00, 8'h3C);
    endtask : test_rx
    initial
    begin
        repeat (20000) @(posedge CLK);
        failures++;
        results();
    end
    initial
    begin
        repeat (10) @(negedge CLK);
        NRST = 1'b1;
        repeat (4) @(negedge CLK);
        test_map();
        test_rates();
        test_sf6_tune();
        test_tx_frame();
        test_explicit();
        test_rx();
        results();
    end
endmodule : spread_spectrum_modem_params_test
`default_nettype wire
